// ---- rtl/card_spi_pkg.sv ----
// Shared constants and types for the card serial-peripheral protocol block
package card_spi_pkg;

  // ----------------------------------------------------------------
  // Command indices
  // ----------------------------------------------------------------
  localparam logic [5:0] RESET_CMD = 6'h00;
  localparam logic [5:0] INTERFACE_CONDITION_CMD = 6'h08;
  localparam logic [5:0] STOP_TRANSMISSION_CMD = 6'h0c;
  localparam logic [5:0] SET_BLOCK_LENGTH_CMD = 6'h10;
  localparam logic [5:0] READ_SINGLE_CMD = 6'h11;
  localparam logic [5:0] READ_MULTIPLE_CMD = 6'h12;
  localparam logic [5:0] WRITE_SINGLE_CMD = 6'h18;
  localparam logic [5:0] OPERATING_CONDITION_POLL_CMD = 6'h29;
  localparam logic [5:0] APP_PREFIX_CMD = 6'h37;
  localparam logic [5:0] READ_OPERATING_CONDITIONS_CMD = 6'h3a;
  localparam logic [5:0] CRC_ON_OFF_CMD = 6'h3b;

  // ----------------------------------------------------------------
  // Response bits, tokens, field positions
  // ----------------------------------------------------------------
  localparam int R1_IDLE_BIT = 0;
  localparam int R1_ILLEGAL_BIT = 2;
  localparam int R1_CRC_ERROR_BIT = 3;
  localparam int R1_ADDRESS_ERROR_BIT = 5;
  localparam int R1_PARAMETER_ERROR_BIT = 6;
  localparam int HOST_CAPACITY_ARG_BIT = 30;
  localparam int BLOCK_ADDR_SHIFT = 9;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] TOKEN_START = 8'hfe;
  localparam logic [7:0] TOKEN_READ_ERROR = 8'h01;
  localparam logic [7:0] DATA_ACCEPTED = 8'h05;
  localparam logic [7:0] DATA_CRC_REJECTED = 8'h0b;
  localparam logic [1:0] COMMAND_START_BITS = 2'h1;
  localparam logic [9:0] BLOCK_BYTES = 10'h200;
  localparam logic [10:0] SECTOR_BYTES = 11'h200;
  localparam logic [8:0] OPCOND_VOLTAGE_WINDOW = 9'h1ff;
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [2:0] INIT_POLLS = 3'h2;
  localparam logic [2:0] SHORT_RESP_BYTES = 3'h1;
  localparam logic [2:0] LONG_RESP_BYTES = 3'h5;
  localparam logic [2:0] CMD_LAST_BYTE = 3'h5;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } command_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [9:0] len;
  } block_req_t;

  typedef enum {XFER_IDLE, RD_WAIT, RD_DATA, RD_CRC_HI, RD_CRC_LO,
                WR_TOKEN, WR_DATA, WR_CRC} xfer_t;
  typedef enum {F_IDLE, F_READ} fetch_t;
  typedef enum {ACT_NONE, ACT_ENTER, ACT_RESET, ACT_IFCOND, ACT_POLL,
                ACT_CRC, ACT_SETLEN, ACT_READ, ACT_WRITE, ACT_STOP,
                ACT_APP} action_t;

endpackage

// ---- rtl/crc16_serial.sv ----
// Bit-serial CCITT CRC-16 generator and checker
`timescale 1ns/100ps
`default_nettype none

module crc16_serial
  import card_spi_pkg::*;
(
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic bit_i,
  output logic [15:0] crc_o,
  output logic [15:0] next_crc_o
);

  // Next value with the current bit folded in
  always_comb begin
    next_crc_o = {crc_o[14:0], 1'b0} ^ ((crc_o[15] ^ bit_i) ? CRC16_POLY : 16'h0000);
  end

  // Register, cleared before each block
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      crc_o <= 16'h0000;
    end else if (en_i) begin
      crc_o <= next_crc_o;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/card_spi_protocol.sv ----
// Card-side serial-peripheral protocol engine with block fetch port
//
// Behaviour
// - Enter serial mode only on selected reset
// - Serial mode holds until power cycle
// - Count clocks from select fall, byte aligned
// - Selected card in serial mode answers every command
// - Retrieval failure sends error token, no data
// - Each written block gets data response
// - Standard card: partial lengths within sector
// - High capacity: fixed 512, no protect
// - Echo pattern; echo voltage if accepted, else zero
// - Idle bit set until initialization done
// - Capacity support sampled on first poll
// - Capacity status valid after check, init
// - Command CRC checking starts off
// - CRC checked per on/off setting
// - Condition check command always CRC checked
// - Read answers response then data token
// - CRC-16 appended to every data block
// - Multiple read runs until stop or any other command completes
`timescale 1ns/100ps
`default_nettype none

module card_spi_protocol
  import card_spi_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  input wire logic CARD_HIGH_CAPACITY_I,
  input wire logic PARTIAL_READ_ALLOWED_I,
  input wire logic [3:0] VOLTAGE_WINDOW_I,
  output logic MEM_RD_O,
  output logic [31:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_DATA_I,
  input wire logic MEM_VALID_I,
  input wire logic MEM_ERR_I,
  output logic SPI_MODE_O,
  output logic INIT_DONE_O,
  output logic CRC_CHECK_ON_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] blk_buf [0:511];
  fetch_t fstate;
  logic req_meta, req_sync, req_seen, ack_tgl, fetch_err;
  logic [9:0] fetch_idx, fetch_len;
  logic [2:0] stat_meta, stat_sync;
  logic rst_meta, link_rst, ack_meta, ack_sync, req_tgl;
  logic [5:0] cfg_meta, cfg;
  logic [2:0] bit_cnt, cmd_cnt;
  logic [7:0] rx_sh, tx_sh, rx_byte, next_tx, crc_lo_hold, wr_crc_hi;
  logic [39:0] cmd_buf, resp_buf;
  logic miso, byte_end, cmd_done, done, crc_ok, in_wr_data;
  logic spi_mode, init_done, crc_on, if_ok, host_capacity_support_bit;
  logic first_poll, app_pending, multi, wire_is_data, resp_gap;
  logic [2:0] resp_cnt, polls;
  logic [9:0] blk_len, rd_idx, wr_idx;
  xfer_t xfer;
  block_req_t block_req;
  command_t cmd;
  action_t act;
  logic [7:0] r1;
  logic [31:0] ext;
  logic ext_en, respond, voltage_ok, progress, range_err;
  logic hc, partial, capacity_status;
  logic [3:0] vwin, supplied_voltage_field, voltage_accepted_field;
  logic [10:0] sector_end;
  logic [15:0] tx_crc, tx_crc_next, rx_crc, rx_crc_next;

  // ----------------------------------------------------------------
  // Block fetch on the system clock
  // ----------------------------------------------------------------

  // Request toggle from the link side
  always_ff @(posedge MCLK_I) begin
    req_meta <= req_tgl;
    req_sync <= req_meta;
  end

  // Fetch one block from memory, then toggle the acknowledge
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      fstate <= F_IDLE;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      fetch_err <= 1'b0;
      MEM_RD_O <= 1'b0;
      MEM_ADDR_O <= 32'h00000000;
      fetch_idx <= 10'h000;
      fetch_len <= 10'h000;
    end else begin
      case (fstate)
        F_IDLE: begin
          if (req_sync != req_seen) begin
            req_seen <= req_sync;
            MEM_ADDR_O <= block_req.addr;
            fetch_len <= block_req.len;
            fetch_idx <= 10'h000;
            MEM_RD_O <= 1'b1;
            fstate <= F_READ;
          end
        end
        F_READ: begin
          if (MEM_ERR_I) begin
            MEM_RD_O <= 1'b0;
            fetch_err <= 1'b1;
            ack_tgl <= req_seen;
            fstate <= F_IDLE;
          end else if (MEM_VALID_I) begin
            if (fetch_idx == fetch_len - 10'h001) begin
              MEM_RD_O <= 1'b0;
              fetch_err <= 1'b0;
              ack_tgl <= req_seen;
              fstate <= F_IDLE;
            end else begin
              fetch_idx <= fetch_idx + 10'h001;
              MEM_ADDR_O <= MEM_ADDR_O + 32'h00000001;
            end
          end
        end
        default: fstate <= F_IDLE;
      endcase
    end
  end

  // Block store, written here and read by the link after the ack
  always_ff @(posedge MCLK_I) begin
    if (fstate == F_READ && MEM_VALID_I && !MEM_ERR_I) begin
      blk_buf[fetch_idx[8:0]] <= MEM_DATA_I;
    end
  end

  // Status levels brought back to the system clock
  always_ff @(posedge MCLK_I) begin
    stat_meta <= {spi_mode, init_done, crc_on};
    stat_sync <= stat_meta;
  end

  assign SPI_MODE_O = stat_sync[2];
  assign INIT_DONE_O = stat_sync[1];
  assign CRC_CHECK_ON_O = stat_sync[0];

  // ----------------------------------------------------------------
  // Link clock crossings
  // ----------------------------------------------------------------

  // Reset, configuration and acknowledge synchronisers
  always_ff @(posedge SCLK_I) begin
    rst_meta <= RESET_I;
    link_rst <= rst_meta;
    cfg_meta <= {CARD_HIGH_CAPACITY_I, PARTIAL_READ_ALLOWED_I, VOLTAGE_WINDOW_I};
    cfg <= cfg_meta;
    ack_meta <= ack_tgl;
    ack_sync <= ack_meta;
  end

  assign hc = cfg[5];
  assign partial = cfg[4];
  assign vwin = cfg[3:0];
  assign done = (ack_sync == req_tgl);

  // ----------------------------------------------------------------
  // Byte framing, restarted by every select
  // ----------------------------------------------------------------
  assign byte_end = (bit_cnt == BYTE_LAST_BIT);
  assign rx_byte = {rx_sh[6:0], MOSI_I};
  assign cmd_done = byte_end && (cmd_cnt == CMD_LAST_BYTE);
  assign in_wr_data = (xfer == WR_DATA) || (xfer == WR_CRC);
  assign cmd = {cmd_buf[37:32], cmd_buf[31:0]};
  assign MISO_OE_O = !CS_N_I;
  assign MISO_O = miso;

  // Bit count, shift registers and command capture
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      tx_sh <= IDLE_BYTE;
      cmd_cnt <= 3'h0;
      cmd_buf <= 40'h0000000000;
    end else begin
      bit_cnt <= 3'(bit_cnt + 3'h1);
      rx_sh <= rx_byte;
      tx_sh <= byte_end ? next_tx : {tx_sh[6:0], 1'b1};
      if (byte_end) begin
        if (cmd_cnt != 3'h0) begin
          cmd_cnt <= (cmd_cnt == CMD_LAST_BYTE) ? 3'h0 : 3'(cmd_cnt + 3'h1);
          cmd_buf <= {cmd_buf[31:0], rx_byte};
        end else if (rx_byte[7:6] == COMMAND_START_BITS && !in_wr_data) begin
          cmd_cnt <= 3'h1;
          cmd_buf <= {cmd_buf[31:0], rx_byte};
        end
      end
    end
  end

  // Output bit changes on the falling edge
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      miso <= 1'b1;
    end else begin
      miso <= tx_sh[7];
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction

  assign crc_ok = (crc7(cmd_buf) == rx_byte[7:1]);
  assign supplied_voltage_field = cmd.arg[11:8];
  assign voltage_ok = (supplied_voltage_field != 4'h0)
    && ((supplied_voltage_field & 4'(supplied_voltage_field - 4'h1)) == 4'h0)
    && ((supplied_voltage_field & vwin) != 4'h0);
  assign voltage_accepted_field = voltage_ok ? supplied_voltage_field : 4'h0;
  assign sector_end = 11'(cmd.arg[8:0]) + 11'(blk_len);
  assign range_err = !hc && (sector_end > SECTOR_BYTES);
  assign capacity_status = hc && if_ok && init_done;
  assign progress = !hc || (if_ok && (first_poll ? cmd.arg[HOST_CAPACITY_ARG_BIT]
                                                 : host_capacity_support_bit));

  // Response byte, extension word and action for a finished command
  always_comb begin
    r1 = {7'h00, !init_done};
    ext = 32'h00000000;
    ext_en = 1'b0;
    respond = spi_mode;
    act = ACT_NONE;
    if (!spi_mode) begin
      if (cmd.index == RESET_CMD && crc_ok) begin
        respond = 1'b1;
        r1 = 8'h01;
        act = ACT_ENTER;
      end
    end else if ((crc_on || cmd.index == INTERFACE_CONDITION_CMD) && !crc_ok) begin
      r1[R1_CRC_ERROR_BIT] = 1'b1;
    end else if (xfer inside {RD_WAIT, RD_DATA, RD_CRC_HI, RD_CRC_LO}
                 && cmd.index != STOP_TRANSMISSION_CMD) begin
      r1[R1_ILLEGAL_BIT] = 1'b1;
    end else begin
      case (cmd.index)
        RESET_CMD: begin
          r1 = 8'h01;
          act = ACT_RESET;
        end
        INTERFACE_CONDITION_CMD: begin
          ext = {20'h00000, voltage_accepted_field, cmd.arg[7:0]};
          ext_en = 1'b1;
          act = ACT_IFCOND;
        end
        STOP_TRANSMISSION_CMD: act = ACT_STOP;
        SET_BLOCK_LENGTH_CMD: begin
          if (!init_done) begin
            r1[R1_ILLEGAL_BIT] = 1'b1;
          end else if (!hc && (cmd.arg == 32'h00000000 || cmd.arg > 32'(BLOCK_BYTES)
                      || (!partial && cmd.arg != 32'(BLOCK_BYTES)))) begin
            r1[R1_PARAMETER_ERROR_BIT] = 1'b1;
          end else begin
            act = ACT_SETLEN;
          end
        end
        READ_SINGLE_CMD, READ_MULTIPLE_CMD, WRITE_SINGLE_CMD: begin
          if (!init_done) begin
            r1[R1_ILLEGAL_BIT] = 1'b1;
          end else if (range_err) begin
            r1[R1_ADDRESS_ERROR_BIT] = 1'b1;
          end else begin
            act = (cmd.index == WRITE_SINGLE_CMD) ? ACT_WRITE : ACT_READ;
          end
        end
        APP_PREFIX_CMD: act = ACT_APP;
        READ_OPERATING_CONDITIONS_CMD: begin
          ext = {init_done, capacity_status, 6'h00, OPCOND_VOLTAGE_WINDOW, 15'h0000};
          ext_en = 1'b1;
        end
        CRC_ON_OFF_CMD: act = ACT_CRC;
        OPERATING_CONDITION_POLL_CMD: begin
          if (app_pending) begin
            act = ACT_POLL;
            r1[R1_IDLE_BIT] = !(init_done || (progress && polls == INIT_POLLS - 3'h1));
          end else begin
            r1[R1_ILLEGAL_BIT] = 1'b1;
          end
        end
        default: r1[R1_ILLEGAL_BIT] = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit byte selection
  // ----------------------------------------------------------------
  always_comb begin
    next_tx = IDLE_BYTE;
    if (resp_gap) begin
      next_tx = IDLE_BYTE;
    end else if (resp_cnt != 3'h0) begin
      next_tx = resp_buf[39:32];
    end else begin
      case (xfer)
        RD_WAIT: begin
          if (done) begin
            next_tx = fetch_err ? TOKEN_READ_ERROR : TOKEN_START;
          end
        end
        RD_DATA: next_tx = blk_buf[rd_idx[8:0]];
        RD_CRC_HI: next_tx = tx_crc_next[15:8];
        RD_CRC_LO: next_tx = crc_lo_hold;
        default: next_tx = IDLE_BYTE;
      endcase
    end
  end

  crc16_serial tx_crc_gen (
    .clk_i(SCLK_I),
    .clear_i(xfer == RD_WAIT),
    .en_i(wire_is_data),
    .bit_i(miso),
    .crc_o(tx_crc),
    .next_crc_o(tx_crc_next)
  );

  crc16_serial rx_crc_gen (
    .clk_i(SCLK_I),
    .clear_i(xfer == WR_TOKEN),
    .en_i(xfer == WR_DATA),
    .bit_i(MOSI_I),
    .crc_o(rx_crc),
    .next_crc_o(rx_crc_next)
  );

  // ----------------------------------------------------------------
  // Card state and transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge SCLK_I) begin
    if (link_rst) begin
      spi_mode <= 1'b0;
      crc_on <= 1'b0;
      init_done <= 1'b0;
      if_ok <= 1'b0;
      host_capacity_support_bit <= 1'b0;
      first_poll <= 1'b1;
      polls <= 3'h0;
      app_pending <= 1'b0;
      blk_len <= BLOCK_BYTES;
      xfer <= XFER_IDLE;
      multi <= 1'b0;
      req_tgl <= 1'b0;
      block_req <= '0;
      rd_idx <= 10'h000;
      wr_idx <= 10'h000;
      resp_buf <= 40'h0000000000;
      resp_cnt <= 3'h0;
      resp_gap <= 1'b0;
      wire_is_data <= 1'b0;
      crc_lo_hold <= 8'h00;
      wr_crc_hi <= 8'h00;
    end else if (byte_end) begin
      wire_is_data <= !resp_gap && resp_cnt == 3'h0 && xfer == RD_DATA;
      // Response bytes go out before any block traffic
      if (resp_gap) begin
        resp_gap <= 1'b0;
      end else if (resp_cnt != 3'h0) begin
        resp_buf <= {resp_buf[31:0], 8'h00};
        resp_cnt <= 3'(resp_cnt - 3'h1);
      end else begin
        case (xfer)
          RD_WAIT: begin
            if (done) begin
              xfer <= fetch_err ? XFER_IDLE : RD_DATA;
              rd_idx <= 10'h000;
            end
          end
          RD_DATA: begin
            rd_idx <= rd_idx + 10'h001;
            if (rd_idx == block_req.len - 10'h001) begin
              xfer <= RD_CRC_HI;
            end
          end
          RD_CRC_HI: begin
            crc_lo_hold <= tx_crc_next[7:0];
            xfer <= RD_CRC_LO;
          end
          RD_CRC_LO: begin
            if (multi) begin
              block_req.addr <= block_req.addr + 32'(block_req.len);
              req_tgl <= !req_tgl;
              xfer <= RD_WAIT;
            end else begin
              xfer <= XFER_IDLE;
            end
          end
          default: ;
        endcase
      end
      // Incoming write block and its data response
      case (xfer)
        WR_TOKEN: begin
          if (rx_byte == TOKEN_START) begin
            xfer <= WR_DATA;
            wr_idx <= 10'h000;
          end
        end
        WR_DATA: begin
          wr_idx <= wr_idx + 10'h001;
          if (wr_idx == block_req.len - 10'h001) begin
            xfer <= WR_CRC;
            wr_idx <= 10'h000;
          end
        end
        WR_CRC: begin
          wr_idx <= wr_idx + 10'h001;
          wr_crc_hi <= rx_byte;
          if (wr_idx != 10'h000) begin
            resp_buf <= {(crc_on && {wr_crc_hi, rx_byte} != rx_crc)
                         ? DATA_CRC_REJECTED : DATA_ACCEPTED, 32'h00000000};
            resp_cnt <= SHORT_RESP_BYTES;
            xfer <= XFER_IDLE;
          end
        end
        default: ;
      endcase
      // A finished command answers and may start a transfer
      if (cmd_done) begin
        app_pending <= (act == ACT_APP);
        if (respond) begin
          resp_buf <= {r1, ext};
          resp_cnt <= ext_en ? LONG_RESP_BYTES : SHORT_RESP_BYTES;
          resp_gap <= 1'b1;
        end
        if (spi_mode && !in_wr_data) begin
          xfer <= XFER_IDLE;
        end
        case (act)
          ACT_ENTER: begin
            spi_mode <= 1'b1;
            crc_on <= 1'b0;
          end
          ACT_RESET: begin
            init_done <= 1'b0;
            if_ok <= 1'b0;
            first_poll <= 1'b1;
            polls <= 3'h0;
            blk_len <= BLOCK_BYTES;
          end
          ACT_IFCOND: if_ok <= voltage_ok;
          ACT_POLL: begin
            first_poll <= 1'b0;
            if (first_poll) begin
              host_capacity_support_bit <= cmd.arg[HOST_CAPACITY_ARG_BIT] && if_ok && hc;
            end
            if (progress && !init_done) begin
              if (polls == INIT_POLLS - 3'h1) begin
                init_done <= 1'b1;
              end else begin
                polls <= 3'(polls + 3'h1);
              end
            end
          end
          ACT_CRC: crc_on <= cmd.arg[0];
          ACT_SETLEN: blk_len <= cmd.arg[9:0];
          ACT_READ, ACT_WRITE: begin
            block_req.addr <= hc ? {cmd.arg[22:0], 9'h000} : cmd.arg;
            block_req.len <= hc ? BLOCK_BYTES : blk_len;
            multi <= (cmd.index == READ_MULTIPLE_CMD);
            if (act == ACT_READ) begin
              req_tgl <= !req_tgl;
              xfer <= RD_WAIT;
            end else begin
              xfer <= WR_TOKEN;
            end
          end
          ACT_STOP: multi <= 1'b0;
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/card_spi_checker.sv ----
// Port-level checks for the card protocol engine
`timescale 1ns/100ps
`default_nettype none
module card_spi_checker (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CS_N_I,
  input wire logic MISO_O,
  input wire logic MEM_RD_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic MEM_VALID_I,
  input wire logic MEM_ERR_I,
  input wire logic SPI_MODE_O,
  input wire logic INIT_DONE_O,
  input wire logic CRC_CHECK_ON_O
);
  // ----------------------------
  // Checks on the system clock
  // ----------------------------
  default clocking mck @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  idle_high_a: assert property (CS_N_I |-> MISO_O) else $error("data out low while idle");
  mode_kept_a: assert property (SPI_MODE_O |=> SPI_MODE_O) else $error("serial mode lost");
  init_mode_a: assert property (INIT_DONE_O |-> SPI_MODE_O) else $error("init done outside mode");
  crc_mode_a: assert property ($rose(CRC_CHECK_ON_O) |-> SPI_MODE_O) else $error("crc on outside mode");
  addr_step_a: assert property (MEM_RD_O && MEM_VALID_I && !MEM_ERR_I |=>
    !MEM_RD_O || MEM_ADDR_O == $past(MEM_ADDR_O) + 32'h1) else $error("fetch address not stepped");
  addr_hold_a: assert property (MEM_RD_O && !MEM_VALID_I && !MEM_ERR_I |=>
    MEM_RD_O && $stable(MEM_ADDR_O)) else $error("fetch address moved");
  err_stop_a: assert property (MEM_RD_O && MEM_ERR_I |=> !MEM_RD_O [*2]) else $error("fetch not aborted");
  rd_init_a: assert property ($rose(MEM_RD_O) |-> INIT_DONE_O) else $error("fetch before init");
endmodule
bind card_spi_protocol card_spi_checker u_chk (.MCLK_I, .RESET_I, .CS_N_I, .MISO_O, .MEM_RD_O, .MEM_ADDR_O,
  .MEM_VALID_I, .MEM_ERR_I, .SPI_MODE_O, .INIT_DONE_O, .CRC_CHECK_ON_O);
`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model driving select, serial clock and data
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // Clock rests low and select high outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // One byte each way, 30 ns clock, data set while clock low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #15 sclk_o = 1'b1;
      rx[i] = miso_i;
      #15 sclk_o = 1'b0;
    end
  endtask
  // Host alone opens a frame by pulling select low
  task automatic sel;
    #15 cs_n_o = 1'b0;
  endtask
  // Idle clocks with select high
  task automatic idle(input int n);
    logic [7:0] d;
    cs_n_o = 1'b1;
    repeat (n) xfer(8'hff, d);
  endtask
endmodule
`default_nettype wire

// ---- bench/card_spi_protocol_tb.sv ----
// Self-checking bench for the card protocol engine
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
module card_spi_protocol_tb
  import card_spi_pkg::*;
;
  logic MCLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic SCLK_I, CS_N_I, MOSI_I, MISO_O, MISO_OE_O, MEM_RD_O, SPI_MODE_O, INIT_DONE_O, CRC_CHECK_ON_O;
  logic MEM_VALID_I = 1'b0;
  logic MEM_ERR_I = 1'b0;
  logic err_on = 1'b0;
  logic [7:0] MEM_DATA_I = 8'h00;
  logic [3:0] VOLTAGE_WINDOW_I = 4'h1;
  logic CARD_HIGH_CAPACITY_I = 1'b1;
  logic PARTIAL_READ_ALLOWED_I = 1'b0;
  logic [31:0] MEM_ADDR_O;
  logic [7:0] d;
  int err_count = 0;
  int check_count = 0;
  // Data line has a pull-up when the card lets go
  wire logic miso = MISO_OE_O ? MISO_O : 1'b1;
  card_spi_protocol u_dut (.MCLK_I, .RESET_I, .SCLK_I, .CS_N_I, .MOSI_I, .MISO_O, .MISO_OE_O,
    .CARD_HIGH_CAPACITY_I, .PARTIAL_READ_ALLOWED_I, .VOLTAGE_WINDOW_I, .MEM_RD_O,
    .MEM_ADDR_O, .MEM_DATA_I, .MEM_VALID_I, .MEM_ERR_I, .SPI_MODE_O, .INIT_DONE_O, .CRC_CHECK_ON_O);
  host_model u_host (.sclk_o(SCLK_I), .cs_n_o(CS_N_I), .mosi_o(MOSI_I), .miso_i(miso));
  initial begin
    forever #50 MCLK_I = ~MCLK_I;
  end
  // Memory answers every other cycle with the low address byte
  always @(posedge MCLK_I) begin
    MEM_VALID_I <= MEM_RD_O && !MEM_VALID_I && !err_on;
    MEM_DATA_I <= MEM_ADDR_O[7:0];
    MEM_ERR_I <= MEM_RD_O && err_on;
  end
  function automatic logic [6:0] crc7(input logic [39:0] f);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((c[6] ^ f[i]) ? CRC7_POLY : 7'h00);
    return c;
  endfunction
  function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction
  // Six-byte command, two gap bytes, then the first response byte
  task automatic cmd(input logic [5:0] ix, input logic [31:0] a, input bit bad, input logic [7:0] e);
    logic [39:0] f;
    f = {COMMAND_START_BITS, ix, a};
    u_host.sel();
    for (int i = 0; i < 5; i++) u_host.xfer(f[39 - 8 * i -: 8], d);
    u_host.xfer({crc7(f) ^ {6'h00, bad}, 1'b1}, d);
    repeat (3) u_host.xfer(8'hff, d);
    `CHK(d, e)
  endtask
  // Four trailing response bytes
  task automatic tail(input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(8'hff, d);
      `CHK(d, e[31 - 8 * i -: 8])
    end
  endtask
  // Token after idle bytes, then four data bytes and their CRC
  task automatic rdblk(input logic [7:0] tok, input logic [7:0] a0);
    logic [15:0] c;
    int n;
    c = 16'h0000;
    n = 0;
    d = IDLE_BYTE;
    while (d === IDLE_BYTE && n < 100) begin
      u_host.xfer(8'hff, d);
      n++;
    end
    `CHK(d, tok)
    for (int i = 0; i < 4 && tok === TOKEN_START; i++) begin
      u_host.xfer(8'hff, d);
      `CHK(d, a0 + 8'(i))
      c = c16(c, a0 + 8'(i));
    end
    if (tok === TOKEN_START) begin
      tail({c, 16'hffff} | 32'h0000ffff);
    end
  endtask
  // Start token, n data and CRC bytes, then the data response
  task automatic wrblk(input int n);
    u_host.xfer(TOKEN_START, d);
    repeat (n) u_host.xfer(8'h5a, d);
    repeat (2) u_host.xfer(8'hff, d);
    `CHK(d, DATA_ACCEPTED)
  endtask
  task automatic t_entry;
    `CHK(MISO_OE_O, 1'b0)
    cmd(INTERFACE_CONDITION_CMD, 32'h1aa, 0, IDLE_BYTE);
    `CHK(SPI_MODE_O, 1'b0)
    cmd(RESET_CMD, 32'h0, 0, 8'h01);
    cmd(RESET_CMD, 32'h0, 1, 8'h01);
    `CHK(CRC_CHECK_ON_O, 1'b0)
    `CHK(SPI_MODE_O, 1'b1)
    cmd(CRC_ON_OFF_CMD, 32'h1, 0, 8'h01);
    cmd(RESET_CMD, 32'h0, 1, 8'h09);
    `CHK(CRC_CHECK_ON_O, 1'b1)
    cmd(CRC_ON_OFF_CMD, 32'h0, 0, 8'h01);
  endtask
  task automatic t_init;
    cmd(INTERFACE_CONDITION_CMD, 32'h1aa, 1, 8'h09);
    @(posedge MCLK_I) VOLTAGE_WINDOW_I <= 4'h2;
    cmd(INTERFACE_CONDITION_CMD, 32'h1aa, 0, 8'h01);
    tail(32'h000000aa);
    @(posedge MCLK_I) VOLTAGE_WINDOW_I <= 4'h1;
    cmd(INTERFACE_CONDITION_CMD, 32'h1aa, 0, 8'h01);
    tail(32'h000001aa);
    for (int p = 0; p < 2; p++) begin
      cmd(APP_PREFIX_CMD, 32'h0, 0, 8'h01);
      cmd(OPERATING_CONDITION_POLL_CMD, 32'h40000000, 0, 8'(1 - p));
    end
    cmd(READ_OPERATING_CONDITIONS_CMD, 32'h0, 0, 8'h00);
    u_host.xfer(8'hff, d);
    `CHK(d, 8'hc0)
    repeat (3) u_host.xfer(8'hff, d);
    `CHK(INIT_DONE_O, 1'b1)
  endtask
  task automatic t_data;
    cmd(SET_BLOCK_LENGTH_CMD, 32'h4, 0, 8'h00);
    cmd(WRITE_SINGLE_CMD, 32'h1, 0, 8'h00);
    wrblk(514);
    @(posedge MCLK_I) CARD_HIGH_CAPACITY_I <= 1'b0;
    cmd(SET_BLOCK_LENGTH_CMD, 32'h0, 0, 8'h40);
    cmd(SET_BLOCK_LENGTH_CMD, 32'h4, 0, 8'h40);
    @(posedge MCLK_I) PARTIAL_READ_ALLOWED_I <= 1'b1;
    cmd(SET_BLOCK_LENGTH_CMD, 32'h4, 0, 8'h00);
    cmd(READ_SINGLE_CMD, 32'h1fe, 0, 8'h20);
    cmd(6'h05, 32'h0, 0, 8'h04);
    cmd(READ_SINGLE_CMD, 32'h10, 0, 8'h00);
    rdblk(TOKEN_START, 8'h10);
    err_on = 1'b1;
    cmd(READ_SINGLE_CMD, 32'h10, 0, 8'h00);
    rdblk(TOKEN_READ_ERROR, 8'h00);
    err_on = 1'b0;
    cmd(READ_MULTIPLE_CMD, 32'h20, 0, 8'h00);
    rdblk(TOKEN_START, 8'h20);
    rdblk(TOKEN_START, 8'h24);
    cmd(STOP_TRANSMISSION_CMD, 32'h0, 0, 8'h00);
    tail(32'hffffffff);
    cmd(WRITE_SINGLE_CMD, 32'h40, 0, 8'h00);
    wrblk(6);
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset with idle clocks running, then the scenarios
  initial begin
    fork
      u_host.idle(10);
      begin
        repeat (3) @(posedge MCLK_I);
        RESET_I <= 1'b0;
      end
    join
    t_entry();
    t_init();
    t_data();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #5000000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
